// ==== inc/exec_pkg.sv ====
// Shared constants and carrier types for the bit-clear / flag-branch unit.
// Assumes one clock domain and an AXI4-Lite master with 32-bit data.
`default_nettype none
package exec_pkg;
  // ==========================================================
  // Register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_INSTR = 8'h04;
  localparam logic [7:0] OFF_PC = 8'h08;
  localparam logic [7:0] OFF_BANK = 8'h0C;
  localparam logic [7:0] OFF_INDEX = 8'h10;
  localparam logic [7:0] OFF_FLAGS = 8'h14;
  localparam logic [7:0] OFF_STATUS = 8'h18;
  // ==========================================================
  // Opcode fields and codes
  localparam logic [3:0] OPC_BIT_CLEAR = 4'h9;
  localparam logic [7:0] OPC_BR_NEG = 8'hE6;
  localparam logic [7:0] OPC_BR_NO_CARRY = 8'hE3;
  localparam logic [7:0] INDEX_LIMIT = 8'h5F;
  localparam logic [7:0] ACCESS_SPLIT = 8'h80;
  localparam logic [3:0] ACCESS_HI_BANK = 4'hF;
  localparam logic [3:0] ACCESS_LO_BANK = 4'h0;
  localparam logic [20:0] PC_STEP = 21'h0_0002;
  // ==========================================================
  // Phases of one instruction cycle
  localparam logic [1:0] PH_Q1 = 2'h0;
  localparam logic [1:0] PH_Q2 = 2'h1;
  localparam logic [1:0] PH_Q3 = 2'h2;
  localparam logic [1:0] PH_Q4 = 2'h3;
  // ==========================================================
  // Reset values and bus answers
  localparam logic [20:0] PC_RESET = 21'h0_0000;
  localparam logic [15:0] OPCODE_RESET = 16'h0000;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {ST_IDLE, ST_EXEC, ST_FLUSH} execState_e;
  typedef struct packed {
    logic awvalid; logic [7:0] awaddr; logic wvalid; logic [31:0] wdata;
    logic [3:0] wstrb; logic bready; logic arvalid; logic [7:0] araddr; logic rready;
  } axiReq_s;
  typedef struct packed {
    logic awready; logic wready; logic bvalid; logic [1:0] bresp;
    logic arready; logic rvalid; logic [31:0] rdata; logic [1:0] rresp;
  } axiRsp_s;
  typedef struct packed {
    logic rdEn; logic wrEn; logic [11:0] addr; logic [7:0] wrData;
  } memReq_s;
endpackage
`default_nettype wire

// ==== design/bit_clear_branch_exec.sv ====
// Execution unit for bit clear of a file register and two flag branches.
// Assumes a byte data memory with combinational read on the same clock,
// and software that launches one opcode at a time over AXI4-Lite.
//
// Local design decisions: register access over AXI4-Lite and the register offsets.
`timescale 1ns/1ps
`default_nettype none
// How it works
// - Clear chosen bit of chosen register
// - Access bit zero selects access bank
// - Access bit one uses bank pointer
// - Extended set, low addresses use indexing
// - Negative branch taken only when set
// - Offset signed, doubled before adding
// - Target is instruction address plus two plus offset
// - One cycle untaken, two cycles taken
// - No-carry branch taken when carry clear
module bit_clear_branch_exec (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire exec_pkg::axiReq_s axiReq,
  output exec_pkg::axiRsp_s axiRsp,
  output exec_pkg::memReq_s memReq,
  input wire logic [7:0] memRdData
);
  import exec_pkg::*;
  // ==========================================================
  // Software-visible state
  logic extEnable_q; // Extended instruction set on
  logic [3:0] bankPtr_q; // Bank pointer register
  logic [11:0] indexBase_q; // Base for indexed literal offset
  logic flagN_q; // Negative flag
  logic flagC_q; // Carry flag
  logic [20:0] pc_q; // Program counter
  logic [15:0] opcode_q; // Opcode under execution
  // ==========================================================
  // Sequencer state
  execState_e state_q;
  logic [1:0] phase_q;
  logic isClear_q, isNegBranch_q, isNoCarryBranch_q; // Decoded kind
  logic indexed_q; // Operand used indexing
  logic taken_q; // Branch condition met
  logic [20:0] target_q; // Branch destination
  logic [7:0] offset_q; // Literal read in Q2
  logic [7:0] rdData_q; // Register value read in Q2
  logic [7:0] wrData_q; // Value to write back
  logic [11:0] memAddr_q; // Operand address
  // ==========================================================
  // Bus slave state
  logic awHeld_q, wHeld_q, bvalid_q, rvalid_q;
  logic [7:0] awAddr_q;
  logic [31:0] wData_q, rdata_q;
  logic [3:0] wStrb_q;
  logic [1:0] bresp_q, rresp_q;
  logic doWrite, launch, busy;
  logic [31:0] wMask, rdMux;
  logic rdHit;

  // Write happens once both address and data are held
  assign doWrite = awHeld_q && wHeld_q && !bvalid_q;
  assign busy = (state_q != ST_IDLE);
  // New opcodes are refused while the sequencer runs
  assign launch = doWrite && (awAddr_q == OFF_INSTR) && !busy;
  // Byte lanes map to a bit mask so partial writes merge cleanly
  assign wMask = {{8{wStrb_q[3]}}, {8{wStrb_q[2]}}, {8{wStrb_q[1]}}, {8{wStrb_q[0]}}};

  assign axiRsp.awready = !awHeld_q && !bvalid_q;
  assign axiRsp.wready = !wHeld_q && !bvalid_q;
  assign axiRsp.bvalid = bvalid_q;
  assign axiRsp.bresp = bresp_q;
  assign axiRsp.arready = !rvalid_q;
  assign axiRsp.rvalid = rvalid_q;
  assign axiRsp.rdata = rdata_q;
  assign axiRsp.rresp = rresp_q;

  // ==========================================================
  // Write channels: address and data may arrive in either order
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      awHeld_q <= 1'b0;
      wHeld_q <= 1'b0;
      awAddr_q <= 8'h00;
      wData_q <= 32'h0000_0000;
      wStrb_q <= 4'h0;
    end else begin
      if (doWrite) begin
        awHeld_q <= 1'b0;
        wHeld_q <= 1'b0;
      end
      if (axiReq.awvalid && axiRsp.awready) begin
        awHeld_q <= 1'b1;
        awAddr_q <= axiReq.awaddr;
      end
      if (axiReq.wvalid && axiRsp.wready) begin
        wHeld_q <= 1'b1;
        wData_q <= axiReq.wdata;
        wStrb_q <= axiReq.wstrb;
      end
    end
  end

  // Write response; unmapped or busy-time launches answer SLVERR
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
    end else if (doWrite) begin
      bvalid_q <= 1'b1;
      unique case (awAddr_q)
        OFF_CTRL, OFF_BANK, OFF_INDEX, OFF_FLAGS, OFF_STATUS: bresp_q <= RESP_OKAY;
        OFF_INSTR, OFF_PC: bresp_q <= busy ? RESP_SLVERR : RESP_OKAY;
        default: bresp_q <= RESP_SLVERR;
      endcase
    end else if (bvalid_q && axiReq.bready) begin
      bvalid_q <= 1'b0;
    end
  end

  // Configuration registers steering address formation and branches
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      extEnable_q <= 1'b0;
      bankPtr_q <= 4'h0;
      indexBase_q <= 12'h000;
      flagN_q <= 1'b0;
      flagC_q <= 1'b0;
    end else if (doWrite) begin
      unique case (awAddr_q)
        OFF_CTRL: extEnable_q <= wStrb_q[0] ? wData_q[0] : extEnable_q;
        OFF_BANK: bankPtr_q <= wStrb_q[0] ? wData_q[3:0] : bankPtr_q;
        OFF_INDEX: indexBase_q <= (indexBase_q & ~wMask[11:0]) | (wData_q[11:0] & wMask[11:0]);
        OFF_FLAGS: begin
          flagC_q <= wStrb_q[0] ? wData_q[0] : flagC_q;
          flagN_q <= wStrb_q[0] ? wData_q[1] : flagN_q;
        end
        default: begin
        end
      endcase
    end
  end

  // Read mux; status shows the sequencer's own state
  always_comb begin
    rdMux = 32'h0000_0000;
    rdHit = 1'b1;
    unique case (axiReq.araddr)
      OFF_CTRL: rdMux[0] = extEnable_q;
      OFF_INSTR: rdMux[15:0] = opcode_q;
      OFF_PC: rdMux[20:0] = pc_q;
      OFF_BANK: rdMux[3:0] = bankPtr_q;
      OFF_INDEX: rdMux[11:0] = indexBase_q;
      OFF_FLAGS: rdMux[1:0] = {flagN_q, flagC_q};
      OFF_STATUS: rdMux[2:0] = {indexed_q, taken_q, busy};
      default: rdHit = 1'b0;
    endcase
  end

  // Read channel answers one cycle after the address is taken
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= RESP_OKAY;
    end else if (axiReq.arvalid && axiRsp.arready) begin
      rvalid_q <= 1'b1;
      rdata_q <= rdMux;
      rresp_q <= rdHit ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid_q && axiReq.rready) begin
      rvalid_q <= 1'b0;
    end
  end

  // ==========================================================
  // Phase sequencer: one cycle is four clocks, Q1 to Q4
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= ST_IDLE;
      phase_q <= PH_Q1;
    end else begin
      unique case (state_q)
        ST_IDLE: begin
          if (launch) begin
            state_q <= ST_EXEC;
            phase_q <= PH_Q1;
          end
        end
        ST_EXEC: begin
          phase_q <= phase_q + 2'h1;
          // Taken branch spends a second cycle on the refetch
          if (phase_q == PH_Q4) begin
            state_q <= taken_q ? ST_FLUSH : ST_IDLE;
          end
        end
        ST_FLUSH: begin
          phase_q <= phase_q + 2'h1;
          if (phase_q == PH_Q4) begin
            state_q <= ST_IDLE;
          end
        end
      endcase
    end
  end

  // Opcode capture
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      opcode_q <= OPCODE_RESET;
    end else if (launch) begin
      opcode_q <= wData_q[15:0];
    end
  end

  // Q1 decode: kind and operand address
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      isClear_q <= 1'b0;
      isNegBranch_q <= 1'b0;
      isNoCarryBranch_q <= 1'b0;
      indexed_q <= 1'b0;
      memAddr_q <= 12'h000;
    end else if (state_q == ST_EXEC && phase_q == PH_Q1) begin
      isClear_q <= (opcode_q[15:12] == OPC_BIT_CLEAR);
      isNegBranch_q <= (opcode_q[15:8] == OPC_BR_NEG);
      isNoCarryBranch_q <= (opcode_q[15:8] == OPC_BR_NO_CARRY);
      indexed_q <= 1'b0;
      if (opcode_q[8]) begin
        memAddr_q <= {bankPtr_q, opcode_q[7:0]};
      end else if (extEnable_q && opcode_q[7:0] <= INDEX_LIMIT) begin
        // Wraps inside the 4 KB space rather than faulting
        memAddr_q <= indexBase_q + {4'h0, opcode_q[7:0]};
        indexed_q <= 1'b1;
      end else if (opcode_q[7:0] < ACCESS_SPLIT) begin
        memAddr_q <= {ACCESS_LO_BANK, opcode_q[7:0]};
      end else begin
        memAddr_q <= {ACCESS_HI_BANK, opcode_q[7:0]};
      end
    end
  end

  // Q2 read, Q3 modify for bit clear; Q2 literal, Q3 target for branches
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      rdData_q <= 8'h00;
      wrData_q <= 8'h00;
      offset_q <= 8'h00;
      taken_q <= 1'b0;
      target_q <= PC_RESET;
    end else if (launch) begin
      taken_q <= 1'b0;
    end else if (state_q == ST_EXEC) begin
      if (phase_q == PH_Q2) begin
        rdData_q <= memRdData;
        offset_q <= opcode_q[7:0];
      end
      if (phase_q == PH_Q3) begin
        wrData_q <= rdData_q & ~(8'h01 << opcode_q[11:9]);
        taken_q <= (isNegBranch_q && flagN_q) || (isNoCarryBranch_q && !flagC_q);
        // Sign-extend and double; PC already points past this word
        target_q <= pc_q + {{12{offset_q[7]}}, offset_q, 1'b0};
      end
    end
  end

  // Program counter: software load when idle, step in Q1, jump in Q4
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      pc_q <= PC_RESET;
    end else if (doWrite && awAddr_q == OFF_PC && !busy) begin
      pc_q <= (pc_q & ~wMask[20:0]) | (wData_q[20:0] & wMask[20:0]);
    end else if (state_q == ST_EXEC && phase_q == PH_Q1) begin
      pc_q <= pc_q + PC_STEP;
    end else if (state_q == ST_EXEC && phase_q == PH_Q4 && taken_q) begin
      pc_q <= target_q;
    end
  end

  // Strobes decode the phase; address and data come from flip-flops
  assign memReq.rdEn = (state_q == ST_EXEC) && (phase_q == PH_Q2) && isClear_q;
  assign memReq.wrEn = (state_q == ST_EXEC) && (phase_q == PH_Q4) && isClear_q;
  assign memReq.addr = memAddr_q;
  assign memReq.wrData = wrData_q;

  // ==========================================================
  // Checks
  chk_clear_bit: assert property (@(posedge core_clk) disable iff (!rst_b)
    memReq.wrEn |-> memReq.wrData == ($past(memRdData, 2) & ~(8'h01 << opcode_q[11:9])))
    else $error("bit clear wrote wrong value");
  chk_access_bank: assert property (@(posedge core_clk) disable iff (!rst_b)
    memReq.rdEn && !opcode_q[8] && !indexed_q |->
      memReq.addr[11:8] == (opcode_q[7] ? ACCESS_HI_BANK : ACCESS_LO_BANK))
    else $error("access bank address wrong");
  chk_bank_pointer: assert property (@(posedge core_clk) disable iff (!rst_b)
    memReq.rdEn && opcode_q[8] |-> memReq.addr == {bankPtr_q, opcode_q[7:0]})
    else $error("banked address wrong");
  chk_indexed_mode: assert property (@(posedge core_clk) disable iff (!rst_b)
    memReq.rdEn |-> indexed_q == (extEnable_q && !opcode_q[8] && opcode_q[7:0] <= INDEX_LIMIT))
    else $error("indexed mode chosen wrongly");
  chk_neg_branch: assert property (@(posedge core_clk) disable iff (!rst_b)
    state_q == ST_EXEC && phase_q == PH_Q3 && isNegBranch_q |=> taken_q == $past(flagN_q))
    else $error("negative branch decision wrong");
  chk_carry_branch: assert property (@(posedge core_clk) disable iff (!rst_b)
    state_q == ST_EXEC && phase_q == PH_Q3 && isNoCarryBranch_q |=> taken_q == !$past(flagC_q))
    else $error("no-carry branch decision wrong");
  chk_branch_target: assert property (@(posedge core_clk) disable iff (!rst_b)
    state_q == ST_FLUSH && phase_q == PH_Q1 |->
      pc_q == $past(pc_q, 4) + PC_STEP + {{12{offset_q[7]}}, offset_q, 1'b0})
    else $error("branch target wrong");
  chk_taken_length: assert property (@(posedge core_clk) disable iff (!rst_b)
    state_q == ST_EXEC && phase_q == PH_Q4 && taken_q |=> state_q == ST_FLUSH [*4] ##1 !busy)
    else $error("taken branch not two cycles");
  chk_untaken_quiet: assert property (@(posedge core_clk) disable iff (!rst_b)
    state_q == ST_EXEC && phase_q == PH_Q4 && !taken_q |=> !busy && $stable(pc_q))
    else $error("untaken branch changed PC");
  chk_read_then_write: assert property (@(posedge core_clk) disable iff (!rst_b)
    memReq.rdEn |-> !memReq.wrEn ##2 memReq.wrEn ##1 !busy)
    else $error("bit clear phases out of order");
  chk_flush_idle: assert property (@(posedge core_clk) disable iff (!rst_b)
    state_q == ST_FLUSH |-> !memReq.rdEn && !memReq.wrEn ##1 $stable(pc_q))
    else $error("flush cycle not idle");
endmodule
`default_nettype wire

// ==== tb/tb.sv ====
// Self-checking bench for the bit-clear and flag-branch execution unit.
// Assumes the unit's byte memory is modelled here with a combinational read.
`timescale 1ns/1ps
`default_nettype none
module tb;
  import exec_pkg::*;
  // ==========================================================
  // Clock, reset, bus and memory model
  logic core_clk = 1'b0; // 250 MHz core clock
  logic rst_b = 1'b0; // Active-low reset
  axiReq_s req = '{bready: 1'b1, rready: 1'b1, default: '0}; // Ready lines held high
  axiRsp_s rsp; // Bus answers
  memReq_s mreq; // Memory strobes
  logic [7:0] memRdData; // Read data back to the unit
  logic [7:0] mem [4096]; // Byte memory behind the unit
  int cyc = 0; // Edge counter
  int n_mismatch = 0;
  int n_tests = 0;
  int rdCyc; // Edge of last read strobe
  int wrCyc; // Edge of last write strobe
  int nStrobe = 0; // Strobes seen so far
  logic [11:0] wrAddr; // Address of last write
  logic [7:0] wrDat; // Data of last write

  always #2 core_clk = ~core_clk;
  assign memRdData = mem[mreq.addr];

  bit_clear_branch_exec bit_clear_branch_exec_i (.core_clk(core_clk), .rst_b(rst_b),
    .axiReq(req), .axiRsp(rsp), .memReq(mreq), .memRdData(memRdData));

  // ==========================================================
  // Strobe monitor: timestamps strobes and stores writes
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (mreq.rdEn === 1'b1) begin
      rdCyc = cyc;
      nStrobe++;
    end
    if (mreq.wrEn === 1'b1) begin
      wrCyc = cyc;
      wrAddr = mreq.addr;
      wrDat = mreq.wrData;
      mem[mreq.addr] = mreq.wrData;
      nStrobe++;
    end
  end

  // ==========================================================
  // Bus tasks and comparison
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // Offers address and data together; bready stays high throughout
  // Waits as long as the unit needs; only the watchdog ends a hang
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    req.awvalid <= 1'b1;
    req.awaddr <= a;
    req.wvalid <= 1'b1;
    req.wdata <= d;
    req.wstrb <= 4'hF;
    do begin
      @(posedge core_clk);
      if (rsp.awready === 1'b1) req.awvalid <= 1'b0;
      if (rsp.wready === 1'b1) req.wvalid <= 1'b0;
    end while (rsp.bvalid !== 1'b1);
    r = rsp.bresp;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    req.arvalid <= 1'b1;
    req.araddr <= a;
    do begin
      @(posedge core_clk);
      if (rsp.arready === 1'b1) req.arvalid <= 1'b0;
    end while (rsp.rvalid !== 1'b1);
    d = rsp.rdata;
    r = rsp.rresp;
  endtask

  // ==========================================================
  // Scenarios
  // Launches one bit clear and judges the strobes it makes
  task automatic tBitClear(input logic [2:0] b, input logic a, input logic [7:0] f,
                           input logic [11:0] ea, input logic [7:0] v);
    logic [1:0] r;
    int c0;
    int n0;
    mem[ea] = v;
    n0 = nStrobe;
    wr(OFF_INSTR, {16'h0000, OPC_BIT_CLEAR, b, a, f}, r);
    c0 = cyc;
    // Q4 lands three edges after the response edge; wait a little past it
    repeat (6) @(posedge core_clk);
    cmp(r, RESP_OKAY, "launch answer");
    cmp(nStrobe - n0, 2, "strobe count");
    cmp(rdCyc - c0, 1, "read phase");
    cmp(wrCyc - c0, 3, "write phase");
    cmp(wrAddr, ea, "operand address");
    cmp(wrDat, v & ~(8'h01 << b), "cleared byte");
    $display("bit clear test done, address %h", ea);
  endtask

  // Sets flags and PC, launches a branch, then judges span and target
  task automatic tBranch(input logic [7:0] op, input logic [1:0] fl, input logic [7:0] n,
                         input logic take);
    logic [1:0] r;
    logic [31:0] d;
    logic [20:0] ep;
    int c0;
    int n0;
    int t;
    int sn;
    wr(OFF_FLAGS, {30'h0, fl}, r);
    wr(OFF_PC, 32'h0000_1000, r);
    n0 = nStrobe;
    wr(OFF_INSTR, {16'h0000, op, n}, r);
    c0 = cyc;
    t = 0;
    d = 32'h0000_0001;
    while (d[0] !== 1'b0 && t < 20) begin
      rd(OFF_STATUS, d, r);
      t++;
    end
    t = cyc - c0;
    cmp(d[1], take, "taken flag");
    cmp(take ? (t >= 9 && t <= 12) : (t <= 7), 1, "busy span");
    rd(OFF_PC, d, r);
    // Target worked out in plain integers: start plus two plus twice the offset
    sn = $signed(n);
    ep = take ? 21'(32'h0000_1002 + 2 * sn) : 21'h00_1002;
    cmp(d, {11'h000, ep}, "new program counter");
    cmp(nStrobe - n0, 0, "no memory strobes");
    $display("branch test done, opcode %h offset %h", op, n);
  endtask

  // Reads back the program counter after reset and an unmapped offset
  task automatic tResetMap;
    logic [1:0] r;
    logic [31:0] d;
    rd(OFF_PC, d, r);
    cmp(d, 32'h0000_0000, "pc after reset");
    rd(8'h1C, d, r);
    cmp(r, RESP_SLVERR, "unmapped read answer");
    cmp(d, 32'h0000_0000, "unmapped read data");
    $display("reset and map test done");
  endtask

  // A PC write while a bit clear runs must be refused and leave PC alone
  task automatic tBusyRefusal;
    logic [1:0] r;
    logic [31:0] d;
    wr(OFF_INSTR, {16'h0000, OPC_BIT_CLEAR, 3'd0, 1'b1, 8'h00}, r);
    wr(OFF_PC, 32'h0000_0000, r);
    cmp(r, RESP_SLVERR, "busy write answer");
    repeat (8) @(posedge core_clk);
    rd(OFF_PC, d, r);
    cmp(d, 32'h0000_1004, "pc after refused write");
    $display("busy refusal test done");
  endtask

  // ==========================================================
  // Closing and watchdog
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // Whole run takes a few hundred cycles; ten thousand means a hang
  initial begin
    #40000;
    n_mismatch++;
    tally_and_finish;
  end

  // ==========================================================
  // Main sequence
  initial begin
    logic [1:0] r;
    logic [31:0] d;
    foreach (mem[i]) mem[i] = 8'h00;
    repeat (12) @(posedge core_clk);
    rst_b <= 1'b1;
    @(posedge core_clk);
    tResetMap;
    wr(OFF_BANK, 32'h0000_0003, r);
    tBitClear(3'd7, 1'b1, 8'h25, 12'h325, 8'hC7);
    tBitClear(3'd0, 1'b0, 8'h10, 12'h010, 8'hFF);
    tBitClear(3'd4, 1'b0, 8'h90, 12'hF90, 8'h5A);
    wr(OFF_CTRL, 32'h0000_0001, r);
    wr(OFF_INDEX, 32'h0000_0200, r);
    tBitClear(3'd3, 1'b0, 8'h5F, 12'h25F, 8'h0F);
    rd(OFF_STATUS, d, r);
    cmp(d[2], 1'b1, "indexed operand flag");
    tBitClear(3'd1, 1'b0, 8'h60, 12'h060, 8'h02);
    tBitClear(3'd2, 1'b1, 8'h10, 12'h310, 8'h04);
    tBranch(OPC_BR_NEG, 2'b10, 8'h7F, 1'b1);
    tBranch(OPC_BR_NEG, 2'b01, 8'h80, 1'b0);
    tBranch(OPC_BR_NO_CARRY, 2'b10, 8'h80, 1'b1);
    tBranch(OPC_BR_NO_CARRY, 2'b01, 8'h05, 1'b0);
    // An opcode that is neither branch runs as a one-cycle no-op
    tBranch(8'hE7, 2'b00, 8'h10, 1'b0);
    tBusyRefusal;
    tally_and_finish;
  end
endmodule
`default_nettype wire
